// ---- rtl/ulmcs_top.sv ----
// One serial channel: line format, modem control, line status, serialiser
// Operation
// RULE1: Two low line control bits pick 5, 6, 7 or 8 data bits.
// RULE2: Stop bit set gives 1.5 stops for 5 bits, else two.
// RULE3: Parity enable adds parity on transmit and checks on receive.
// RULE4: Bit 4 picks odd parity when 0, even when 1.
// RULE5: Stick parity sends constant: 1 when bit 4 clear, 0 when set.
// RULE6: Break bit holds transmit output low until cleared.
// RULE7: Bit 7 swaps data registers for the divisor latch.
// RULE8: Modem bit 0 drives DTR output inverted.
// RULE9: Modem bit 1 drives RTS inverted unless automatic flow control.
// RULE10: In loopback bit 2 is internal RI, bit 3 inverted user output two.
// RULE11: Software leaves bit 2 alone while half duplex direction is automatic.
// RULE12: Interrupt output floats only when select pin and bit 3 low.
// RULE13: Modem bit 4 enables local loopback.
// RULE14: Resume-on-any restarts stopped transmit on any received character; an XOFF with software flow control on keeps it stopped.
// RULE15: Infrared mode codes serial lines; idle infrared output is low.
// RULE16: Prescaler bit loads from strap after reset, then writable.
// RULE17: Line status error flags raise interrupt when enabled.
// RULE18: Data ready shows a held received character.
// RULE19: Character arriving with holding full sets overrun, is dropped.
// RULE20: Parity and framing flags belong to the held character.
// RULE21: Long low input sets break, one character, held until mark.
// RULE22: Holding empty flag sets on transfer, clears on host load.
// RULE23: Reading line status clears the error flags.
module ulmcs_top
    import ulmcs_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input  wire logic       mclk,
    input  wire logic       rstn,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       rx_pin,
    input  wire logic       irq_drive_select,
    input  wire logic       prescale_strap_pin,
    output logic            tx_pin,
    output logic            dtr_n,
    output logic            rts_n,
    output logic            user_output_one_n,
    output logic            user_output_two_n,
    output logic            irq,
    output logic            irq_oe
);
    if (DIV_W < 8 || DIV_W > 16) begin : g_chk
        $error("DIV_W must be 8 to 16");
    end

    logic [7:0]       lcr_reg, mcr_reg, dll_reg, dlm_reg, thr_reg, tsr_reg, rhr_reg;
    logic [7:0]       rx_sr_reg, lsr_val;
    logic [3:0]       ier_reg, rx_cnt_reg, ir_ph_reg;
    logic [1:0]       feat_reg, strap_cnt_reg, pre_cnt_reg;
    logic [DIV_W-1:0] baud_cnt_reg, div_val;
    logic [5:0]       tx_cnt_reg, stop_end;
    logic [4:0]       ir_hold_reg;
    logic [2:0]       tx_bit_reg, rx_bit_reg, last_bit;
    logic             rx_meta, rx_sync, sel_meta, sel_sync, strap_meta, strap_sync;
    logic             thr_empty_reg, tx_line_reg, tx_par_reg, tx_halt_reg;
    logic             rx_full_reg, ovr_reg, pe_reg, fe_reg, bi_reg;
    logic             rx_done_reg, rx_perr_reg, rx_fe_reg, rx_bi_reg, rx_zero_reg;
    logic             dlab, data_wr, rhr_rd, lsr_rd, pre_tick, tick, tx_load, tx_bit_end;
    logic             line_out, rx_in, rx_samp, rx_keep, rx_store;
    ulmcs_tx_t        tx_st;
    ulmcs_rx_t        rx_st;

    function automatic logic [7:0] wmask(input logic [7:0] d, input logic [1:0] w);
        wmask = d & (8'hff >> (2'h3 - w));
    endfunction

    function automatic logic par_calc(input logic [7:0] d, input logic [7:0] l);
        if (l[LCR_STICK]) begin
            par_calc = !l[LCR_EPS];
        end else begin
            par_calc = (^wmask(d, l[1:0])) ^ !l[LCR_EPS];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rx_meta    <= 1'h1;
            rx_sync    <= 1'h1;
            sel_meta   <= 1'h0;
            sel_sync   <= 1'h0;
            strap_meta <= 1'h0;
            strap_sync <= 1'h0;
        end else begin
            rx_meta    <= rx_pin;
            rx_sync    <= rx_meta;
            sel_meta   <= irq_drive_select;
            sel_sync   <= sel_meta;
            strap_meta <= prescale_strap_pin;
            strap_sync <= strap_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register access decode
    assign dlab    = lcr_reg[LCR_DLAB];
    assign data_wr = wr && addr == ADR_DATA && !dlab;  // RULE7
    assign rhr_rd  = rd && addr == ADR_DATA && !dlab;  // RULE7
    assign lsr_rd  = rd && addr == ADR_LSR;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            lcr_reg  <= LCR_RST;
            ier_reg  <= IER_RST;
            feat_reg <= FEAT_RST;
            dll_reg  <= DLL_RST;
            dlm_reg  <= DLM_RST;
        end else if (wr) begin
            case (addr)
                ADR_DATA: if (dlab) dll_reg <= wdata;  // RULE7
                ADR_IER: begin
                    if (dlab) dlm_reg <= wdata;
                    else ier_reg <= wdata[3:0];
                end
                ADR_FEAT: feat_reg <= wdata[1:0];
                ADR_LCR:  lcr_reg <= wdata;
                default: ;
            endcase
        end
    end

    // Prescaler bit caught from the strap once it has passed the synchroniser
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            strap_cnt_reg <= 2'h0;
            mcr_reg       <= MCR_RST;
        end else begin
            if (strap_cnt_reg != 2'h3) strap_cnt_reg <= strap_cnt_reg + 2'h1;
            if (wr && addr == ADR_MCR) mcr_reg <= wdata;
            if (strap_cnt_reg == STRAP_LOAD) mcr_reg[MCR_PRE] <= strap_sync;  // RULE16
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler and 16x baud tick
    assign pre_tick = !mcr_reg[MCR_PRE] || pre_cnt_reg == PRE_LAST;  // RULE16
    assign div_val  = DIV_W'({dlm_reg, dll_reg});
    assign tick     = pre_tick && baud_cnt_reg == '0;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pre_cnt_reg  <= 2'h0;
            baud_cnt_reg <= '0;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 2'h1;
            if (pre_tick) begin
                if (baud_cnt_reg != '0) baud_cnt_reg <= baud_cnt_reg - DIV_W'(1);
                else if (div_val > DIV_W'(1)) baud_cnt_reg <= div_val - DIV_W'(1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmitter
    assign last_bit   = 3'h4 + {1'h0, lcr_reg[1:0]};  // RULE1
    assign stop_end   = !lcr_reg[LCR_STB] ? TX_BIT_END :
                        (lcr_reg[1:0] == 2'h0 ? TX_STOP15 : TX_STOP2);  // RULE2
    assign tx_bit_end = tick && tx_cnt_reg == (tx_st == TX_STOP ? stop_end : TX_BIT_END);
    assign tx_load    = tx_st == TX_IDLE && tick && !thr_empty_reg && !tx_halt_reg;
    assign line_out   = !lcr_reg[LCR_BRK] && tx_line_reg;  // RULE6

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx_cnt_reg <= 6'h00;
        end else if (tx_st == TX_IDLE || tx_bit_end) begin
            tx_cnt_reg <= 6'h00;
        end else if (tick) begin
            tx_cnt_reg <= tx_cnt_reg + 6'h01;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx_st       <= TX_IDLE;
            tsr_reg     <= 8'h00;
            tx_bit_reg  <= 3'h0;
            tx_line_reg <= 1'h1;
            tx_par_reg  <= 1'h0;
        end else begin
            case (tx_st)
                TX_IDLE: if (tx_load) begin
                    tsr_reg     <= thr_reg;
                    tx_par_reg  <= par_calc(thr_reg, lcr_reg);  // RULE4 RULE5
                    tx_line_reg <= 1'h0;
                    tx_st       <= TX_START;
                end
                TX_START: if (tx_bit_end) begin
                    tx_bit_reg  <= 3'h0;
                    tx_line_reg <= tsr_reg[0];
                    tx_st       <= TX_DATA;
                end
                TX_DATA: if (tx_bit_end) begin
                    if (tx_bit_reg == last_bit) begin  // RULE1
                        tx_line_reg <= lcr_reg[LCR_PEN] ? tx_par_reg : 1'h1;  // RULE3
                        tx_st       <= lcr_reg[LCR_PEN] ? TX_PAR : TX_STOP;
                    end else begin
                        tx_bit_reg  <= tx_bit_reg + 3'h1;
                        tx_line_reg <= tsr_reg[1];
                        tsr_reg     <= tsr_reg >> 1;
                    end
                end
                TX_PAR: if (tx_bit_end) begin
                    tx_line_reg <= 1'h1;
                    tx_st       <= TX_STOP;
                end
                TX_STOP: if (tx_bit_end) tx_st <= TX_IDLE;  // RULE2
                default: tx_st <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            thr_reg       <= 8'h00;
            thr_empty_reg <= 1'h1;
        end else if (data_wr) begin
            thr_reg       <= wdata;
            thr_empty_reg <= 1'h0;  // RULE22
        end else if (tx_load) begin
            thr_empty_reg <= 1'h1;  // RULE22
        end
    end

    // Software flow control stop and resume
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            tx_halt_reg <= 1'h0;
        end else if (rx_done_reg) begin
            if (mcr_reg[MCR_XANY]) tx_halt_reg <= 1'h0;  // RULE14
            else if (feat_reg[FEAT_SWFC] && rx_sr_reg == XON_CHAR) tx_halt_reg <= 1'h0;
            if (feat_reg[FEAT_SWFC] && rx_sr_reg == XOFF_CHAR) tx_halt_reg <= 1'h1;
        end
    end

    // Infrared pulse phase and transmit pin
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ir_ph_reg <= 4'h0;
            tx_pin    <= 1'h1;
        end else begin
            if (tick) ir_ph_reg <= ir_ph_reg + 4'h1;
            if (mcr_reg[MCR_LOOP]) tx_pin <= !mcr_reg[MCR_IR];  // RULE13
            else if (mcr_reg[MCR_IR]) tx_pin <= !line_out && ir_ph_reg < IR_PULSE;  // RULE15
            else tx_pin <= line_out;  // RULE6
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ir_hold_reg <= 5'h00;
        end else if (rx_sync) begin
            ir_hold_reg <= IR_HOLD;  // RULE15
        end else if (tick && ir_hold_reg != 5'h00) begin
            ir_hold_reg <= ir_hold_reg - 5'h01;
        end
    end

    assign rx_in   = mcr_reg[MCR_LOOP] ? line_out :
                     (mcr_reg[MCR_IR] ? ir_hold_reg == 5'h00 : rx_sync);  // RULE13 RULE15
    assign rx_samp = tick && rx_cnt_reg == RX_SAMP;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rx_cnt_reg <= 4'h0;
        end else if (rx_st == RX_IDLE) begin
            rx_cnt_reg <= 4'h0;
        end else if (tick) begin
            rx_cnt_reg <= (rx_st == RX_START && rx_cnt_reg == RX_MID) ? 4'h0 : rx_cnt_reg + 4'h1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rx_st       <= RX_IDLE;
            rx_sr_reg   <= 8'h00;
            rx_bit_reg  <= 3'h0;
            rx_zero_reg <= 1'h0;
            rx_perr_reg <= 1'h0;
            rx_fe_reg   <= 1'h0;
            rx_bi_reg   <= 1'h0;
            rx_done_reg <= 1'h0;
        end else begin
            rx_done_reg <= 1'h0;
            case (rx_st)
                RX_IDLE: if (tick && !rx_in) rx_st <= RX_START;
                RX_START: if (tick && rx_cnt_reg == RX_MID) begin
                    rx_st       <= rx_in ? RX_IDLE : RX_DATA;
                    rx_bit_reg  <= 3'h0;
                    rx_sr_reg   <= 8'h00;
                    rx_zero_reg <= 1'h1;
                    rx_perr_reg <= 1'h0;
                end
                RX_DATA: if (rx_samp) begin
                    rx_sr_reg[rx_bit_reg] <= rx_in;
                    rx_zero_reg           <= rx_zero_reg && !rx_in;
                    rx_bit_reg            <= rx_bit_reg + 3'h1;
                    if (rx_bit_reg == last_bit) begin  // RULE1
                        rx_st <= lcr_reg[LCR_PEN] ? RX_PAR : RX_STOP;
                    end
                end
                RX_PAR: if (rx_samp) begin
                    rx_perr_reg <= rx_in != par_calc(rx_sr_reg, lcr_reg);  // RULE3 RULE4 RULE5
                    rx_zero_reg <= rx_zero_reg && !rx_in;
                    rx_st       <= RX_STOP;
                end
                RX_STOP: if (rx_samp) begin
                    rx_done_reg <= 1'h1;
                    rx_fe_reg   <= !rx_in;  // RULE20
                    rx_bi_reg   <= rx_zero_reg && !rx_in;  // RULE21
                    rx_st       <= (rx_zero_reg && !rx_in) ? RX_BRK : RX_IDLE;
                end
                RX_BRK: if (rx_in) rx_st <= RX_IDLE;  // RULE21
                default: rx_st <= RX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Holding register and line status flags; a set beats a read-clear
    assign rx_keep  = !(feat_reg[FEAT_SWFC] && (rx_sr_reg == XON_CHAR || rx_sr_reg == XOFF_CHAR));
    assign rx_store = rx_done_reg && rx_keep && (!rx_full_reg || rhr_rd);  // RULE14 RULE19

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rhr_reg     <= 8'h00;
            rx_full_reg <= 1'h0;
            ovr_reg     <= 1'h0;
            pe_reg      <= 1'h0;
            fe_reg      <= 1'h0;
            bi_reg      <= 1'h0;
        end else begin
            if (rx_store) begin
                rhr_reg     <= rx_sr_reg;
                rx_full_reg <= 1'h1;  // RULE18
            end else if (rhr_rd) begin
                rx_full_reg <= 1'h0;  // RULE18
            end
            if (rx_done_reg && rx_keep && !rx_store) ovr_reg <= 1'h1;  // RULE19
            else if (lsr_rd) ovr_reg <= 1'h0;  // RULE23
            if (rx_store) begin
                pe_reg <= rx_perr_reg;  // RULE20
                fe_reg <= rx_fe_reg;  // RULE20
            end else if (lsr_rd) begin
                pe_reg <= 1'h0;  // RULE23
                fe_reg <= 1'h0;
            end
            if (rx_store && rx_bi_reg) bi_reg <= 1'h1;  // RULE21
            else if (lsr_rd && rx_st != RX_BRK) bi_reg <= 1'h0;  // RULE21 RULE23
        end
    end

    assign lsr_val = {1'h0, thr_empty_reg && tx_st == TX_IDLE, thr_empty_reg,
                      bi_reg, fe_reg, pe_reg, ovr_reg, rx_full_reg};

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 8'h00;
        end else if (!rd) begin
            rdata <= 8'h00;
        end else begin
            case (addr)
                ADR_DATA: rdata <= dlab ? dll_reg : rhr_reg;  // RULE7
                ADR_IER:  rdata <= dlab ? dlm_reg : {4'h0, ier_reg};
                ADR_FEAT: rdata <= {6'h00, feat_reg};
                ADR_LCR:  rdata <= lcr_reg;
                ADR_MCR:  rdata <= mcr_reg;
                ADR_LSR:  rdata <= lsr_val;
                ADR_LOOP: rdata <= {6'h00, !mcr_reg[MCR_IRQEN], mcr_reg[MCR_RI]};  // RULE10
                default:  rdata <= 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Modem outputs and interrupt pin
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            dtr_n             <= 1'h1;
            rts_n             <= 1'h1;
            user_output_one_n <= 1'h1;
            user_output_two_n <= 1'h1;
            irq               <= 1'h0;
            irq_oe            <= 1'h0;
        end else begin
            dtr_n             <= mcr_reg[MCR_LOOP] || !mcr_reg[MCR_DTR];  // RULE8 RULE13
            rts_n             <= mcr_reg[MCR_LOOP] || (feat_reg[FEAT_ARTS] ?
                                 rx_full_reg : !mcr_reg[MCR_RTS]);  // RULE9
            user_output_one_n <= mcr_reg[MCR_LOOP] || !mcr_reg[MCR_RI];
            user_output_two_n <= mcr_reg[MCR_LOOP] || !mcr_reg[MCR_IRQEN];  // RULE10
            irq               <= ier_reg[IER_RLS] && (ovr_reg || pe_reg || fe_reg || bi_reg);  // RULE17
            irq_oe            <= sel_sync || mcr_reg[MCR_IRQEN];  // RULE12
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_lsr_read;
        lsr_rd && !rx_done_reg;
    endsequence

    sequence s_data_load;
        data_wr ##1 !thr_empty_reg;
    endsequence

    a_break_line: assert property (lcr_reg[LCR_BRK] && !mcr_reg[MCR_LOOP] && !mcr_reg[MCR_IR]
        |=> tx_pin == 1'h0) else $error("break not driving low");  // RULE6
    a_dtr_drive: assert property (!mcr_reg[MCR_LOOP] |=> dtr_n == !$past(mcr_reg[MCR_DTR]))
        else $error("dtr level wrong");  // RULE8
    a_rts_manual: assert property (!mcr_reg[MCR_LOOP] && !feat_reg[FEAT_ARTS]
        |=> rts_n == !$past(mcr_reg[MCR_RTS])) else $error("rts level wrong");  // RULE9
    a_irq_float: assert property (##1 irq_oe == ($past(sel_sync) || $past(mcr_reg[MCR_IRQEN])))
        else $error("irq enable wrong");  // RULE12
    a_loop_quiet: assert property (mcr_reg[MCR_LOOP] && !mcr_reg[MCR_IR]
        |=> tx_pin && dtr_n && rts_n) else $error("loopback pins active");  // RULE13
    a_strap_load: assert property (strap_cnt_reg == STRAP_LOAD
        |=> mcr_reg[MCR_PRE] == $past(strap_sync)) else $error("strap not taken");  // RULE16
    a_lsr_irq: assert property (ier_reg[IER_RLS] && (ovr_reg || pe_reg)
        |=> irq) else $error("status irq missing");  // RULE17
    a_rd_empty: assert property (rhr_rd && !rx_done_reg |=> !rx_full_reg)
        else $error("data ready kept");  // RULE18
    a_ovr_set: assert property (rx_done_reg && rx_keep && rx_full_reg && !rhr_rd
        |=> ovr_reg && $stable(rhr_reg)) else $error("overrun wrong");  // RULE19
    a_thr_load: assert property (data_wr |-> s_data_load)
        else $error("holding empty kept");  // RULE22
    a_lsr_clear: assert property (s_lsr_read |=> !ovr_reg && !pe_reg && !fe_reg)
        else $error("status not cleared");  // RULE23
    a_ir_idle: assert property (mcr_reg[MCR_IR] && !mcr_reg[MCR_LOOP] && tx_st == TX_IDLE
        && tx_line_reg && !lcr_reg[LCR_BRK] |=> !tx_pin) else $error("ir idle high");  // RULE15
endmodule // ulmcs_top

// ---- rtl/ulmcs_pkg.sv ----
// Constants and types of the serial channel line, modem and status block
package ulmcs_pkg;
    // Register addresses
    localparam logic [2:0] ADR_DATA = 3'h0;
    localparam logic [2:0] ADR_IER  = 3'h1;
    localparam logic [2:0] ADR_FEAT = 3'h2;
    localparam logic [2:0] ADR_LCR  = 3'h3;
    localparam logic [2:0] ADR_MCR  = 3'h4;
    localparam logic [2:0] ADR_LSR  = 3'h5;
    localparam logic [2:0] ADR_LOOP = 3'h6;
    // Line control fields
    localparam int LCR_STB   = 2;
    localparam int LCR_PEN   = 3;
    localparam int LCR_EPS   = 4;
    localparam int LCR_STICK = 5;
    localparam int LCR_BRK   = 6;
    localparam int LCR_DLAB  = 7;
    // Modem control fields
    localparam int MCR_DTR   = 0;
    localparam int MCR_RTS   = 1;
    localparam int MCR_RI    = 2;
    localparam int MCR_IRQEN = 3;
    localparam int MCR_LOOP  = 4;
    localparam int MCR_XANY  = 5;
    localparam int MCR_IR    = 6;
    localparam int MCR_PRE   = 7;
    // Interrupt enable and feature fields
    localparam int IER_RLS   = 2;
    localparam int FEAT_ARTS = 0;
    localparam int FEAT_SWFC = 1;
    // Reset values
    localparam logic [7:0]  LCR_RST  = 8'h00;
    localparam logic [7:0]  MCR_RST  = 8'h00;
    localparam logic [3:0]  IER_RST  = 4'h0;
    localparam logic [1:0]  FEAT_RST = 2'h0;
    localparam logic [7:0]  DLL_RST  = 8'h01;
    localparam logic [7:0]  DLM_RST  = 8'h00;
    // Flow control characters
    localparam logic [7:0]  XON_CHAR  = 8'h11;
    localparam logic [7:0]  XOFF_CHAR = 8'h13;
    // Oversampling counts, 16 ticks per bit, then strap load and prescaler clock counts
    localparam logic [5:0]  TX_BIT_END = 6'h0f;
    localparam logic [5:0]  TX_STOP15  = 6'h17;
    localparam logic [5:0]  TX_STOP2   = 6'h1f;
    localparam logic [3:0]  RX_MID     = 4'h7;
    localparam logic [3:0]  RX_SAMP    = 4'hf;
    localparam logic [3:0]  IR_PULSE   = 4'h3;
    localparam logic [4:0]  IR_HOLD    = 5'h10;
    localparam logic [1:0]  STRAP_LOAD = 2'h2;
    localparam logic [1:0]  PRE_LAST   = 2'h3;

    typedef enum logic [4:0] {
        TX_IDLE  = 5'b00001,
        TX_START = 5'b00010,
        TX_DATA  = 5'b00100,
        TX_PAR   = 5'b01000,
        TX_STOP  = 5'b10000
    } ulmcs_tx_t;

    typedef enum logic [5:0] {
        RX_IDLE  = 6'b000001,
        RX_START = 6'b000010,
        RX_DATA  = 6'b000100,
        RX_PAR   = 6'b001000,
        RX_STOP  = 6'b010000,
        RX_BRK   = 6'b100000
    } ulmcs_rx_t;
endpackage

// ---- testbench/ulmcs_remote.sv ----
// Remote serial device driving the receive line
module ulmcs_remote (
    input  wire logic mclk,
    output logic      line
);
    timeunit 1ns;
    timeprecision 1ns;
    initial line = 1'b1;
    task automatic put(input logic b, input int t);
        line <= b;
        repeat (t) @(posedge mclk);
    endtask
    // Start, data LSB first, optional parity, stop and idle mark
    task automatic send(input logic [7:0] d, input int n, input logic pe, input logic pv);
        @(posedge mclk);
        put(1'b0, 16);
        for (int i = 0; i < n; i++) put(d[i], 16);
        if (pe) put(pv, 16);
        put(1'b1, 48);
    endtask
endmodule // ulmcs_remote

// ---- testbench/ulmcs_tb_top.sv ----
// Self-checking bench of the serial channel block
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module uart_line_modem_control_status_tb_top
    import ulmcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk = 0, rstn = 0, wr = 0, rd = 0, sel = 0, strap = 1;
    logic [2:0] addr = '0;
    logic [7:0] wdata = '0, rdata;
    logic       rx_pin, tx_pin, dtr_n, rts_n, irq, irq_oe, u1_n, u2_n;
    int         err_count = 0, cmp_count = 0;
    always #20 mclk = ~mclk;
    ulmcs_top dut (.mclk(mclk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .rx_pin(rx_pin), .irq_drive_select(sel),
        .prescale_strap_pin(strap), .tx_pin(tx_pin), .dtr_n(dtr_n), .rts_n(rts_n),
        .user_output_one_n(u1_n), .user_output_two_n(u2_n), .irq(irq), .irq_oe(irq_oe));
    ulmcs_remote remote (.mclk(mclk), .line(rx_pin));
    ////////////////////////////////////////////////////////////////////////////
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [2:0] a, input logic [7:0] e, input string n);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 `CHK(n, e, rdata)
    endtask
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rreg(ADR_LCR, 8'h00, "lcr");
        rreg(ADR_MCR, 8'h80, "mcr strap");
        rreg(ADR_LSR, 8'h60, "lsr");
        rreg(3'h7, 8'h00, "unmapped");
        wreg(ADR_LCR, 8'h80);
        wreg(ADR_DATA, 8'h02);
        rreg(ADR_DATA, 8'h02, "divisor low");
        rreg(ADR_LSR, 8'h60, "holding untouched");
        wreg(ADR_DATA, 8'h01);
        wreg(ADR_LCR, 8'h00);
        `CHK("dtr_n", 1'b1, dtr_n)
    endtask
    task automatic t_modem();
        wreg(ADR_MCR, 8'h07);
        rreg(ADR_MCR, 8'h07, "mcr");
        settle(3);
        `CHK("dtr_n", 1'b0, dtr_n)
        `CHK("rts_n", 1'b0, rts_n)
        `CHK("out1_n", 1'b0, u1_n)
        `CHK("irq_oe off", 1'b0, irq_oe)
        wreg(ADR_MCR, 8'h1c);
        settle(4);
        `CHK("irq_oe on", 1'b1, irq_oe)
        `CHK("dtr_n loop", 1'b1, dtr_n)
        `CHK("out1_n loop", 1'b1, u1_n)
        `CHK("out2_n loop", 1'b1, u2_n)
        rreg(ADR_LOOP, 8'h01, "loop status");
        wreg(ADR_MCR, 8'h40);
        settle(3);
        `CHK("ir idle", 1'b0, tx_pin)
        wreg(ADR_MCR, 8'h00);
    endtask
    // Waits for a start bit, then samples n bits near their middle
    task automatic grab(input int n, output logic [9:0] f, output int k);
        k = 0;
        f = '0;
        @(negedge mclk);
        while (tx_pin !== 1'b0 && k < 200) begin
            @(negedge mclk);
            k++;
        end
        `CHK("tx start", 1'b0, tx_pin)
        repeat (8) @(negedge mclk);
        for (int i = 0; i < n; i++) begin
            repeat (16) @(negedge mclk);
            f[i] = tx_pin;
        end
    endtask
    task automatic t_tx();
        logic [9:0] f;
        int         k;
        wreg(ADR_LCR, 8'h1b);
        wreg(ADR_DATA, 8'ha7);
        grab(10, f, k);
        `CHK("tx frame", 10'h3a7, f)
        wreg(ADR_LCR, 8'h5b);
        settle(4);
        `CHK("break", 1'b0, tx_pin)
        wreg(ADR_LCR, 8'h1b);
        settle(4);
        `CHK("break off", 1'b1, tx_pin)
        wreg(ADR_LCR, 8'h2c);
        wreg(ADR_DATA, 8'h35);
        wreg(ADR_DATA, 8'h0a);
        grab(7, f, k);
        `CHK("stick frame", 10'h075, f)
        grab(7, f, k);
        `CHK("stop 1.5", 16, k)
        `CHK("five bits", 10'h06a, f)
        wreg(ADR_LCR, 8'h1b);
    endtask
    task automatic t_rx();
        wreg(ADR_IER, 8'h04);
        remote.send(8'h55, 8, 1'b1, 1'b1);
        settle(2);
        `CHK("irq", 1'b1, irq)
        rreg(ADR_LSR, 8'h65, "lsr parity");
        rreg(ADR_LSR, 8'h61, "lsr cleared");
        rreg(ADR_DATA, 8'h55, "rx data");
        rreg(ADR_LSR, 8'h60, "lsr empty");
        remote.send(8'h0f, 8, 1'b1, 1'b0);
        remote.send(8'h33, 8, 1'b1, 1'b0);
        rreg(ADR_LSR, 8'h63, "lsr overrun");
        rreg(ADR_DATA, 8'h0f, "kept data");
        @(posedge mclk);
        remote.put(1'b0, 200);
        rreg(ADR_LSR, 8'h79, "lsr break");
        @(posedge mclk);
        remote.put(1'b1, 40);
        rreg(ADR_LSR, 8'h71, "break kept");
        rreg(ADR_LSR, 8'h61, "break gone");
        rreg(ADR_DATA, 8'h00, "break char");
        wreg(ADR_FEAT, 8'h02);
        remote.send(XOFF_CHAR, 8, 1'b1, 1'b1);
        wreg(ADR_DATA, 8'h41);
        rreg(ADR_LSR, 8'h00, "tx halted");
        wreg(ADR_MCR, 8'h20);
        remote.send(8'h0f, 8, 1'b1, 1'b0);
        rreg(ADR_LSR, 8'h21, "tx resumed");
        rreg(ADR_DATA, 8'h0f, "resume char");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        settle(4);
        t_reset();
        t_modem();
        t_tx();
        t_rx();
        end_of_test();
    end
    initial begin
        repeat (5000) @(posedge mclk);
        err_count++;
        end_of_test();
    end
endmodule // uart_line_modem_control_status_tb_top
